// >>> src/cesq_defs.svh
// constants for the condition, event and queue status block
// assumes inclusion by bare name from package and modules
`ifndef CESQ_DEFS_SVH
`define CESQ_DEFS_SVH
`define CESQ_BIT_SWEEP 0
`define CESQ_BIT_OUT_ON 1
`define CESQ_BIT_EXT_RJ 2
`define CESQ_BIT_LVL_CHG 3
`define CESQ_BIT_INT_RJ 4
`define CESQ_BIT_FAN 5
`define CESQ_BIT_TEMP 7
`define CESQ_BIT_SUPPLY 8
`define CESQ_BIT_OUC 10
`define CESQ_BIT_OSC 11
`define CESQ_BIT_OVLD 12
`define CESQ_BIT_OVCUR 14
`define CESQ_BIT_RJ_ATT 15
`define CESQ_COND_USED_MASK 16'hddbf
`define CESQ_STB_ERR_PEND 2
`define CESQ_STB_EXT_SUM 3
`define CESQ_STB_REPLY_PEND 4
`define CESQ_ERR_UNDEF_HDR 10'h071
`define CESQ_ERR_OVERFLOW 10'h15e
`define CESQ_LVL_CHG_MS 500
`define CESQ_CLK_HZ 25000000
`define CESQ_LVL_CHG_CYC ((`CESQ_CLK_HZ / 1000) * `CESQ_LVL_CHG_MS)
`define CESQ_FILT_RESET 2'h0
`endif

// >>> src/cesq_pkg.sv
// types for the condition, event and queue status block
// assumes cesq_defs.svh on the include path
`include "cesq_defs.svh"
package cesq_pkg;
   typedef enum logic [1:0] {
      CESQ_NO_EDGE_SELECT = 2'h0,
      CESQ_RISE = 2'h1,
      CESQ_FALL = 2'h2,
      CESQ_BOTH = 2'h3
   } cesq_edge_t;
   typedef struct packed {
      logic sweep_running;
      logic output_on;
      logic ext_junction_valid;
      logic int_junction_valid;
      logic fan_halt;
      logic overtemp_fault;
      logic supply_fault;
      logic out_ctrl_fail;
      logic amp_oscillation;
      logic overvoltage_load;
      logic overcurrent_input;
      logic junction_sensor_attached;
   } cesq_inst_t;
   typedef struct packed {
      logic [9:0] code;
      logic [7:0] text_id;
   } cesq_err_t;
endpackage

// >>> src/cesq_fifo.sv
// small fifo used for the reply and error queues
// assumes one clock; flush and write no_edge_select meet a read on an empty queue
`timescale 1ns/1ps
`default_nettype none
module cesq_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8,
   parameter bit OVF_REPLACE = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   input wire logic [W-1:0] ovf_data,
   input wire logic rd_en,
   output logic [W-1:0] rd_data,
   output logic empty,
   output logic full
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] rp_r, rp_nxt, wp_r, wp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic do_rd, do_wr, do_ovf;
   function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
      inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction
   always_comb begin
      do_rd = rd_en && (cnt_r != '0);
      do_wr = wr_en && (cnt_r != (AW+1)'(DEPTH) || do_rd);
      do_ovf = OVF_REPLACE && wr_en && !do_wr;
      rp_nxt = do_rd ? inc(rp_r) : rp_r;
      wp_nxt = do_wr ? inc(wp_r) : wp_r;
      cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      if (flush) begin
         rp_nxt = '0;
         wp_nxt = '0;
         cnt_nxt = '0;
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rp_r <= '0;
         wp_r <= '0;
         cnt_r <= '0;
      end else begin
         rp_r <= rp_nxt;
         wp_r <= wp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   // last slot sits just behind the write pointer when full
   always_ff @(posedge ref_clk) begin
      if (!flush && do_wr) begin
         mem_r[wp_r] <= wr_data;
      end else if (!flush && do_ovf) begin
         mem_r[(wp_r == '0) ? AW'(DEPTH - 1) : wp_r - 1'b1] <= ovf_data;
      end
   end
   always_comb begin
      rd_data = mem_r[rp_r];
      empty = (cnt_r == '0);
      full = (cnt_r == (AW+1)'(DEPTH));
   end
endmodule
`default_nettype wire

// >>> src/cesq_top.sv
// condition register, transition filter, extended events and the two queues
// assumes instrument status pins are asynchronous; command strobes are on ref_clk
// outputs are registered and trail their sources by one clock
`timescale 1ns/1ps
`default_nettype none
`include "cesq_defs.svh"
module cesq_top #(
   parameter int REPLY_W = 8,
   parameter int REPLY_DEPTH = 16,
   parameter int ERR_DEPTH = 8,
   parameter int LVL_CHG_CYC = `CESQ_LVL_CHG_CYC
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire cesq_pkg::cesq_inst_t inst_status,
   input wire logic level_change_pulse,
   input wire logic filt_wr,
   input wire logic [4:0] filt_index,
   input wire cesq_pkg::cesq_edge_t filt_mode,
   input wire logic [4:0] filt_rd_index,
   input wire logic [15:0] event_enable,
   input wire logic event_read,
   input wire logic new_message,
   input wire logic deadlock,
   input wire logic device_clear,
   input wire logic clear_status,
   input wire logic restart,
   input wire logic reply_wr,
   input wire logic [REPLY_W-1:0] reply_data,
   input wire logic reply_rd,
   input wire logic err_wr,
   input wire cesq_pkg::cesq_err_t err_data,
   input wire logic undef_header,
   input wire logic err_rd,
   output logic [15:0] internal_state_flags,
   output logic [15:0] latched_state_events,
   output cesq_pkg::cesq_edge_t filt_rd_mode,
   output logic [REPLY_W-1:0] reply_out,
   output cesq_pkg::cesq_err_t err_out,
   output logic [7:0] status_bits
);
   import cesq_pkg::*;
   typedef enum logic [1:0] {
      CESQ_LC_IDLE = 2'b01,
      CESQ_LC_HOLD = 2'b10
   } cesq_lc_t;
   // two-stage synchronisers for asynchronous status pins
   logic [12:0] s1_r, s2_r;
   logic [12:0] pin_raw;
   always_comb begin
      pin_raw = {level_change_pulse, inst_status};
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
      end
   end
   cesq_inst_t st;
   logic lvl_req, out_prev_r;
   always_comb begin
      st = cesq_inst_t'(s2_r[11:0]);
      lvl_req = s2_r[12];
   end
   // level change hold timer
   // a change pulse shorter than one clock may be missed by the synchroniser
   cesq_lc_t lc_r, lc_nxt;
   logic [$clog2(LVL_CHG_CYC+1)-1:0] lc_cnt_r, lc_cnt_nxt;
   logic lc_trig;
   logic out_rise, out_prev_nxt;
   always_comb begin
      out_rise = st.output_on && !out_prev_r;
      out_prev_nxt = st.output_on;
      lc_trig = lvl_req || out_rise;
      lc_nxt = lc_r;
      lc_cnt_nxt = lc_cnt_r;
      case (lc_r)
         CESQ_LC_IDLE: begin
            if (lc_trig) begin
               lc_nxt = CESQ_LC_HOLD;
               lc_cnt_nxt = '0;
            end
         end
         CESQ_LC_HOLD: begin
            if (lc_trig) begin
               lc_cnt_nxt = '0;
            end else if (lc_cnt_r == $bits(lc_cnt_r)'(LVL_CHG_CYC - 1)) begin
               lc_nxt = CESQ_LC_IDLE;
            end else begin
               lc_cnt_nxt = lc_cnt_r + 1'b1;
            end
         end
         default: begin
            lc_nxt = CESQ_LC_IDLE;
            lc_cnt_nxt = '0;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lc_r <= CESQ_LC_IDLE;
         lc_cnt_r <= '0;
         out_prev_r <= 1'b0;
      end else begin
         lc_r <= lc_nxt;
         lc_cnt_r <= lc_cnt_nxt;
         out_prev_r <= out_prev_nxt;
      end
   end
   // bits six, nine and thirteen no_edge_select hold state
   function automatic logic [15:0] used_only(input logic [15:0] v);
      used_only = v & 16'(`CESQ_COND_USED_MASK);
   endfunction
   // condition register assembly, one clock behind the synchronised levels
   logic [15:0] cond_nxt, cond_r;
   always_comb begin
      cond_nxt = '0;
      cond_nxt[`CESQ_BIT_SWEEP] = st.sweep_running;
      cond_nxt[`CESQ_BIT_OUT_ON] = st.output_on;
      cond_nxt[`CESQ_BIT_EXT_RJ] = st.ext_junction_valid;
      cond_nxt[`CESQ_BIT_INT_RJ] = st.int_junction_valid;
      cond_nxt[`CESQ_BIT_LVL_CHG] = (lc_r == CESQ_LC_HOLD);
      cond_nxt[`CESQ_BIT_FAN] = st.fan_halt;
      cond_nxt[`CESQ_BIT_TEMP] = st.overtemp_fault;
      cond_nxt[`CESQ_BIT_SUPPLY] = st.supply_fault;
      cond_nxt[`CESQ_BIT_OUC] = st.out_ctrl_fail;
      cond_nxt[`CESQ_BIT_OSC] = st.amp_oscillation;
      cond_nxt[`CESQ_BIT_OVLD] = st.overvoltage_load;
      cond_nxt[`CESQ_BIT_OVCUR] = st.overcurrent_input;
      cond_nxt[`CESQ_BIT_RJ_ATT] = st.junction_sensor_attached;
      cond_nxt = used_only(cond_nxt);
   end
   // transition filter and extended event latch
   logic [31:0] filt_r, filt_nxt;
   logic [15:0] evt_r, evt_nxt;
   // no_edge_select, or an unknown code, yields no edge
   function automatic logic edge_hit(input logic [1:0] m, input logic prev, input logic cur);
      case (cesq_edge_t'(m))
         CESQ_RISE: edge_hit = !prev && cur;
         CESQ_FALL: edge_hit = prev && !cur;
         CESQ_BOTH: edge_hit = prev ^ cur;
         default: edge_hit = 1'b0;
      endcase
   endfunction
   logic [3:0] wr_bit, rd_bit;
   logic [15:0] edge_hits;
   // index one to sixteen names condition bit index minus one
   function automatic logic [3:0] index_bit(input logic [4:0] idx);
      index_bit = 4'(idx - 5'h01);
   endfunction
   function automatic logic index_ok(input logic [4:0] idx);
      index_ok = (idx >= 5'h01) && (idx <= 5'h10);
   endfunction
   always_comb begin
      wr_bit = index_bit(filt_index);
      filt_nxt = filt_r;
      // writes outside one to sixteen are ignored
      if (filt_wr && index_ok(filt_index)) begin
         filt_nxt[wr_bit*2 +: 2] = filt_mode;
      end
      // restart returns every filter to no_edge_select
      if (restart) begin
         filt_nxt = {16{`CESQ_FILT_RESET}};
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_r <= {16{`CESQ_FILT_RESET}};
      end else begin
         filt_r <= filt_nxt;
      end
   end
   // an edge in a clearing cycle is kept, so no event is lost to a read
   always_comb begin
      edge_hits = '0;
      for (int i = 0; i < 16; i++) begin
         edge_hits[i] = edge_hit(filt_r[i*2 +: 2], cond_r[i], cond_nxt[i]);
      end
      evt_nxt = (event_read || clear_status) ? 16'h0000 : evt_r;
      evt_nxt = used_only(evt_nxt | edge_hits);
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_r <= '0;
      end else begin
         evt_r <= evt_nxt;
      end
   end
   // previous condition value feeds the edge filters
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_r <= '0;
      end else begin
         cond_r <= cond_nxt;
      end
   end
   // reply and error queues
   logic reply_flush, err_flush, err_push;
   logic reply_empty, err_empty;
   logic [REPLY_W-1:0] reply_head;
   cesq_err_t err_head, err_in, err_ovf;
   // a flush beats a push in the same cycle inside the fifo
   always_comb begin
      reply_flush = new_message || deadlock || device_clear || restart;
   end
   // a caller-supplied entry wins over an unknown header in the same cycle
   always_comb begin
      err_flush = clear_status || restart;
      err_push = err_wr || undef_header;
      err_in = err_wr ? err_data : cesq_err_t'{`CESQ_ERR_UNDEF_HDR, 8'h00};
      err_ovf = cesq_err_t'{`CESQ_ERR_OVERFLOW, 8'h01};
   end
   cesq_fifo #(.W(REPLY_W), .DEPTH(REPLY_DEPTH), .OVF_REPLACE(1'b0)) u_reply (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .flush(reply_flush),
      .wr_en(reply_wr),
      .wr_data(reply_data),
      .ovf_data(reply_data),
      .rd_en(reply_rd),
      .rd_data(reply_head),
      .empty(reply_empty),
      .full()
   );
   cesq_fifo #(.W($bits(cesq_err_t)), .DEPTH(ERR_DEPTH), .OVF_REPLACE(1'b1)) u_err (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .flush(err_flush),
      .wr_en(err_push),
      .wr_data(err_in),
      .ovf_data(err_ovf),
      .rd_en(err_rd),
      .rd_data(err_head),
      .empty(err_empty),
      .full()
   );
   // registered outputs; an empty queue shows zero rather than a stale slot
   logic [15:0] flags_nxt, events_nxt;
   cesq_edge_t rd_mode_nxt;
   logic [REPLY_W-1:0] reply_out_nxt;
   cesq_err_t err_out_nxt;
   logic [7:0] status_nxt;
   always_comb begin
      rd_bit = index_bit(filt_rd_index);
      flags_nxt = cond_r;
      events_nxt = evt_r;
      rd_mode_nxt = cesq_edge_t'(filt_r[rd_bit*2 +: 2]);
      // a readback index outside one to sixteen shows no_edge_select
      if (!index_ok(filt_rd_index)) begin
         rd_mode_nxt = CESQ_NO_EDGE_SELECT;
      end
      reply_out_nxt = reply_empty ? '0 : reply_head;
      err_out_nxt = err_empty ? '0 : err_head;
      status_nxt = 8'h00;
      status_nxt[`CESQ_STB_REPLY_PEND] = !reply_empty;
      status_nxt[`CESQ_STB_ERR_PEND] = !err_empty;
      status_nxt[`CESQ_STB_EXT_SUM] = |(evt_r & event_enable);
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         internal_state_flags <= '0;
         latched_state_events <= '0;
         filt_rd_mode <= CESQ_NO_EDGE_SELECT;
         reply_out <= '0;
         err_out <= '0;
         status_bits <= '0;
      end else begin
         internal_state_flags <= flags_nxt;
         latched_state_events <= events_nxt;
         filt_rd_mode <= rd_mode_nxt;
         reply_out <= reply_out_nxt;
         err_out <= err_out_nxt;
         status_bits <= status_nxt;
      end
   end
endmodule
`default_nettype wire

// >>> tb/cesq_top_props.sv
// checker for the condition, event and queue status block
// assumes the top module's ports only; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module cesq_top_props #(
   parameter int LVL_CHG_CYC = 20
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic level_change_pulse,
   input wire logic filt_wr,
   input wire logic [4:0] filt_index,
   input wire cesq_pkg::cesq_edge_t filt_mode,
   input wire logic [4:0] filt_rd_index,
   input wire logic [15:0] event_enable,
   input wire logic new_message,
   input wire logic deadlock,
   input wire logic device_clear,
   input wire logic clear_status,
   input wire logic restart,
   input wire logic reply_wr,
   input wire logic err_wr,
   input wire logic undef_header,
   input wire logic [15:0] internal_state_flags,
   input wire logic [15:0] latched_state_events,
   input wire cesq_pkg::cesq_edge_t filt_rd_mode,
   input wire logic [7:0] status_bits
);
   import cesq_pkg::*;
   logic flush_any;
   logic [15:0] flags_q;
   logic [2:0] chg_h;
   logic [31:0] lvl_cnt;
   assign flush_any = new_message | deadlock | device_clear | restart;
   // change history of the condition register and level-change high time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= '0;
         chg_h <= '0;
         lvl_cnt <= '0;
      end else begin
         flags_q <= internal_state_flags;
         chg_h <= {chg_h[1:0], internal_state_flags != flags_q};
         if (internal_state_flags[3] && !level_change_pulse && !internal_state_flags[1])
            lvl_cnt <= lvl_cnt + 32'h1;
         else
            lvl_cnt <= '0;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_push;
      reply_wr && !flush_any;
   endsequence
   sequence s_flush_quiet;
      flush_any ##1 !reply_wr;
   endsequence
   sequence s_filt_write;
      filt_wr && !restart && filt_index == filt_rd_index && filt_index inside {[5'h01:5'h10]}
      ##1 !filt_wr && !restart && $stable(filt_rd_index);
   endsequence
   a_unused_zero: assert property ((internal_state_flags & 16'h2240) == 16'h0000)
      else $error("reserved condition bit set");
   a_reply_set: assert property (s_push |-> ##2 status_bits[4])
      else $error("reply pending missing after push");
   a_reply_flush: assert property (s_flush_quiet |=> !status_bits[4])
      else $error("reply queue not flushed");
   a_err_clear: assert property (clear_status && !err_wr && !undef_header
      ##1 !err_wr && !undef_header |=> !status_bits[2]) else $error("errors kept on clear");
   a_sum_set: assert property ((|(latched_state_events & event_enable)) [*3] |-> status_bits[3])
      else $error("summary bit missing");
   a_sum_clr: assert property (((latched_state_events & event_enable) == 16'h0) [*3]
      |-> !status_bits[3]) else $error("summary bit without event");
   a_event_cause: assert property (|(latched_state_events & ~$past(latched_state_events))
      |-> (internal_state_flags != flags_q) || (|chg_h)) else $error("event without change");
   a_lvl_clear: assert property (lvl_cnt <= LVL_CHG_CYC + 6)
      else $error("level change bit held too long");
   a_filt_readback: assert property (s_filt_write |=> filt_rd_mode == $past(filt_mode, 2))
      else $error("filter readback differs");
endmodule
bind cesq_top cesq_top_props #(.LVL_CHG_CYC(LVL_CHG_CYC)) u_props (.ref_clk(ref_clk),
   .rst_n(rst_n), .level_change_pulse(level_change_pulse), .filt_wr(filt_wr),
   .filt_index(filt_index), .filt_mode(filt_mode), .filt_rd_index(filt_rd_index),
   .event_enable(event_enable), .new_message(new_message), .deadlock(deadlock),
   .device_clear(device_clear), .clear_status(clear_status), .restart(restart),
   .reply_wr(reply_wr), .err_wr(err_wr), .undef_header(undef_header),
   .internal_state_flags(internal_state_flags), .latched_state_events(latched_state_events),
   .filt_rd_mode(filt_rd_mode), .status_bits(status_bits));
`default_nettype wire

// >>> tb/cesq_ctl_model.sv
// remote controller model: command strobes, replies, errors, filter writes
// assumes the bench calls its tasks; every strobe lasts one clock
`timescale 1ns/1ps
`default_nettype none
module cesq_ctl_model (
   input wire logic ref_clk,
   output logic [11:0] strobes,
   output logic [7:0] reply_data,
   output cesq_pkg::cesq_err_t err_data,
   output logic [4:0] filt_index,
   output cesq_pkg::cesq_edge_t filt_mode
);
   import cesq_pkg::*;
   initial begin
      strobes = '0;
      reply_data = '0;
      err_data = '0;
      filt_index = '0;
      filt_mode = CESQ_NO_EDGE_SELECT;
   end
   // data is scrambled once released so stale values are no_edge_select trusted
   task automatic send(input logic [11:0] s);
      @(negedge ref_clk);
      strobes = s;
      @(negedge ref_clk);
      strobes = '0;
      reply_data = ~reply_data;
      err_data = ~err_data;
   endtask
   task automatic set_filter(input logic [4:0] idx, input cesq_edge_t m);
      filt_index = idx;
      filt_mode = m;
      send(12'h001);
   endtask
   task automatic push_reply(input logic [7:0] d);
      reply_data = d;
      send(12'h040);
   endtask
   task automatic push_error(input logic [9:0] c);
      err_data = {c, 8'h02};
      send(12'h010);
   endtask
endmodule
`default_nettype wire

// >>> tb/cesq_top_tb_top.sv
// self-checking bench for the condition, event and queue status block
// assumes the controller model drives all command strobes
`timescale 1ns/1ps
`default_nettype none
module cesq_top_tb_top;
   import cesq_pkg::*;
   localparam int LVL = 20;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   cesq_inst_t inst_status = '0;
   logic level_change_pulse = 1'b0;
   logic [4:0] filt_rd_index = 5'h01;
   logic [15:0] event_enable = 16'h0000;
   logic [11:0] strb;
   logic filt_wr, event_read, err_rd, undef_header, err_wr, reply_rd;
   logic reply_wr, clear_status, restart, device_clear, deadlock, new_message;
   assign {new_message, deadlock, device_clear, restart, clear_status, reply_wr, reply_rd,
      err_wr, undef_header, err_rd, event_read, filt_wr} = strb;
   logic [7:0] reply_data, reply_out, status_bits;
   logic [4:0] filt_index;
   cesq_edge_t filt_mode, filt_rd_mode;
   cesq_err_t err_data, err_out;
   logic [15:0] internal_state_flags, latched_state_events;
   int mismatches = 0;
   int cmp_count = 0;
   cesq_ctl_model ctl (.ref_clk(ref_clk), .strobes(strb), .reply_data(reply_data),
      .err_data(err_data), .filt_index(filt_index), .filt_mode(filt_mode));
   cesq_top #(.LVL_CHG_CYC(LVL)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
      .inst_status(inst_status), .level_change_pulse(level_change_pulse), .filt_wr(filt_wr),
      .filt_index(filt_index), .filt_mode(filt_mode), .filt_rd_index(filt_rd_index),
      .event_enable(event_enable), .event_read(event_read), .new_message(new_message),
      .deadlock(deadlock), .device_clear(device_clear), .clear_status(clear_status),
      .restart(restart), .reply_wr(reply_wr), .reply_data(reply_data), .reply_rd(reply_rd),
      .err_wr(err_wr), .err_data(err_data), .undef_header(undef_header), .err_rd(err_rd),
      .internal_state_flags(internal_state_flags), .latched_state_events(latched_state_events),
      .filt_rd_mode(filt_rd_mode), .reply_out(reply_out), .err_out(err_out),
      .status_bits(status_bits));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic test_conditions();
      int map [12] = '{15, 14, 12, 11, 10, 8, 7, 5, 4, 2, 1, 0};
      for (int i = 0; i < 12; i++) begin
         inst_status = cesq_inst_t'(12'h001 << i);
         wait_cyc(6);
         chk(internal_state_flags, (32'h1 << map[i]) | ((i == 10) ? 32'h8 : 32'h0));
         inst_status = '0;
         wait_cyc(LVL + 8);
         chk(internal_state_flags, 32'h0);
      end
      inst_status = '1;
      wait_cyc(6);
      chk(internal_state_flags, 32'hddbf);
      chk(latched_state_events, 32'h0);
      inst_status = '0;
      wait_cyc(LVL + 8);
      level_change_pulse = 1'b1;
      wait_cyc(2);
      level_change_pulse = 1'b0;
      wait_cyc(4);
      chk(internal_state_flags, 32'h8);
      wait_cyc(LVL + 8);
      $display("test conditions done");
   endtask
   task automatic test_filters();
      logic [4:0] idx [2] = '{5'h01, 5'h10};
      int sb [2] = '{11, 0};
      logic [15:0] eb;
      for (int k = 0; k < 2; k++) begin
         eb = 16'h0001 << (idx[k] - 5'h01);
         event_enable = eb;
         filt_rd_index = idx[k];
         for (int m = 0; m < 4; m++) begin
            ctl.set_filter(idx[k], cesq_edge_t'(m));
            ctl.set_filter(5'h00, CESQ_BOTH);
            ctl.set_filter(5'h11, CESQ_BOTH);
            wait_cyc(2);
            chk(filt_rd_mode, m);
            inst_status = cesq_inst_t'(12'h001 << sb[k]);
            wait_cyc(7);
            chk(latched_state_events, (m == CESQ_RISE || m == CESQ_BOTH) ? eb : 16'h0);
            chk(status_bits[3], (m == CESQ_RISE || m == CESQ_BOTH));
            ctl.send(12'h002);
            wait_cyc(2);
            inst_status = '0;
            wait_cyc(7);
            chk(latched_state_events, (m == CESQ_FALL || m == CESQ_BOTH) ? eb : 16'h0);
            ctl.send(12'h002);
            wait_cyc(3);
         end
      end
      event_enable = 16'h0000;
      $display("test filters done");
   endtask
   task automatic test_errors();
      ctl.send(12'h008);
      for (int i = 1; i < 9; i++) ctl.push_error(i[9:0]);
      wait_cyc(3);
      chk(status_bits, 8'h04);
      chk(err_out, {10'h071, 8'h00});
      for (int i = 0; i < 8; i++) begin
         chk(err_out, (i == 0) ? {10'h071, 8'h00} : (i == 7) ? {10'h15e, 8'h01} : {i[9:0], 8'h02});
         ctl.send(12'h004);
         wait_cyc(3);
      end
      chk(status_bits[2], 1'b0);
      ctl.push_error(10'h005);
      ctl.send(12'h080);
      wait_cyc(3);
      chk(status_bits[2], 1'b0);
      ctl.push_error(10'h006);
      ctl.send(12'h100);
      wait_cyc(3);
      chk(status_bits[2], 1'b0);
      $display("test errors done");
   endtask
   task automatic test_reply();
      for (int i = 0; i < 17; i++) ctl.push_reply(8'h10 + i[7:0]);
      ctl.send(12'h080);
      wait_cyc(3);
      chk(status_bits, 8'h10);
      for (int i = 0; i < 16; i++) begin
         chk(reply_out, 8'h10 + i);
         ctl.send(12'h020);
         wait_cyc(3);
      end
      chk(status_bits, 8'h00);
      for (int f = 0; f < 4; f++) begin
         ctl.push_reply(8'h5a);
         ctl.send(12'h100 << f);
         wait_cyc(3);
         chk(status_bits[4], 1'b0);
      end
      $display("test reply done");
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      wait_cyc(2);
      test_conditions();
      test_filters();
      test_errors();
      test_reply();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      report_and_stop();
   end
endmodule
`default_nettype wire
